// ---- design/uarx_top.sv ----
/*
  Asynchronous receive front end: oversampling clock recovery, majority
  vote data recovery and an AXI4-Lite register slave with interrupt.
  Assumes RXD_IN idles high and is asynchronous to CORE_CLK_IN.
*/
// Implementation choices: the register offsets and register access over AXI4-Lite.
module uarx_top import uarx_pkg::*; #(
  parameter int DIV_W = 12
) (
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic RXD_IN,
  input wire logic AXI_AWVALID_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic [AXI_AW-1:0] AXI_AWADDR_IN,
  input wire logic AXI_WVALID_IN,
  output logic AXI_WREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  output logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  output logic [1:0] AXI_BRESP_OUT,
  input wire logic AXI_ARVALID_IN,
  output logic AXI_ARREADY_OUT,
  input wire logic [AXI_AW-1:0] AXI_ARADDR_IN,
  output logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN,
  output logic [31:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  output logic RX_VALID_OUT,
  output logic [FRAME_W-1:0] RX_DATA_OUT,
  output logic RX_FE_OUT,
  output logic IRQ_OUT
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [DIV_W-1:0] baud_cnt;
    uarx_fsm_t fsm;
    logic [4:0] samp;
    logic [3:0] bitn;
    logic [1:0] votes;
    logic [FRAME_W-1:0] frame;
    logic armed;
    logic en;
    logic dbl;
    logic [3:0] fbits;
    logic [DIV_W-1:0] baud;
    logic [FRAME_W-1:0] last_data;
    logic last_fe;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic rx_valid;
    logic [FRAME_W-1:0] rx_data;
    logic rx_fe;
    logic awh;
    logic wh;
    logic [AXI_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } uarx_state_t;

  localparam uarx_state_t S_RESET = '{
    fsm: UARX_IDLE,
    en: CTRL_EN_RST,
    dbl: CTRL_DBL_RST,
    fbits: FBITS_RST,
    irq_mask: IRQ_MASK_RST,
    default: '0
  };

  uarx_state_t s_q;
  uarx_state_t s_d;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic is_reg(input logic [AXI_AW-1:0] a);
    is_reg = (a == REG_CTRL) || (a == REG_BAUD) || (a == REG_STATUS) ||
             (a == REG_DATA) || (a == REG_IRQ_STAT) || (a == REG_IRQ_MASK);
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  always_comb begin
    logic [4:0] spb;
    logic [4:0] sfirst;
    logic [4:0] smid;
    logic [4:0] slast;
    logic [4:0] nsamp;
    logic [3:0] bidx;
    logic [3:0] fb;
    logic vote;
    logic [31:0] m;
    logic [31:0] rw;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    spb = '0;
    sfirst = '0;
    smid = '0;
    slast = '0;
    nsamp = '0;
    bidx = '0;
    fb = '0;
    vote = 1'b0;
    m = '0;
    rw = '0;
    irq_set = '0;
    irq_clr = '0;
    s_d = s_q;
    s_d.rx_valid = 1'b0;

    // Metastability guard on the asynchronous line
    s_d.sync1 = RXD_IN;
    s_d.sync2 = s_q.sync1;

    if (AXI_AWVALID_IN && s_q.awready) begin
      s_d.awh = 1'b1;
      s_d.awaddr = AXI_AWADDR_IN;
    end
    if (AXI_WVALID_IN && s_q.wready) begin
      s_d.wh = 1'b1;
      s_d.wdata = AXI_WDATA_IN;
      s_d.wstrb = AXI_WSTRB_IN;
    end
    if (s_q.bvalid && AXI_BREADY_IN) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.awh && s_q.wh && !s_q.bvalid) begin
      m = lane_mask(s_q.wstrb);
      s_d.awh = 1'b0;
      s_d.wh = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = is_reg(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_q.awaddr)
        REG_CTRL: begin
          if (s_q.wstrb[0]) begin
            s_d.en = s_q.wdata[CTRL_EN_BIT];
            s_d.dbl = s_q.wdata[CTRL_DBL_BIT];
            s_d.fbits = s_q.wdata[CTRL_FBITS_LSB +: 4];
          end
        end
        REG_BAUD: begin
          s_d.baud = (s_q.baud & ~m[DIV_W-1:0]) | (s_q.wdata[DIV_W-1:0] & m[DIV_W-1:0]);
        end
        REG_IRQ_STAT: begin
          irq_clr = s_q.wdata[IRQ_W-1:0] & m[IRQ_W-1:0];
        end
        REG_IRQ_MASK: begin
          if (s_q.wstrb[0]) begin
            s_d.irq_mask = s_q.wdata[IRQ_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    // Each ready is withheld while its own half of the write is parked, and both while a response is pending
    s_d.awready = !s_d.awh && !s_d.bvalid;
    s_d.wready = !s_d.wh && !s_d.bvalid;

    if (s_q.rvalid && AXI_RREADY_IN) begin
      s_d.rvalid = 1'b0;
    end
    if (AXI_ARVALID_IN && s_q.arready) begin
      unique case (AXI_ARADDR_IN)
        REG_CTRL: begin
          rw[CTRL_EN_BIT] = s_q.en;
          rw[CTRL_DBL_BIT] = s_q.dbl;
          rw[CTRL_FBITS_LSB +: 4] = s_q.fbits;
        end
        REG_BAUD: rw[DIV_W-1:0] = s_q.baud;
        REG_STATUS: begin
          rw[STAT_BUSY_BIT] = (s_q.fsm != UARX_IDLE);
          rw[STAT_LINE_BIT] = s_q.sync2;
          rw[STAT_FE_BIT] = s_q.last_fe;
        end
        REG_DATA: begin
          rw[FRAME_W-1:0] = s_q.last_data;
          rw[DATA_FE_BIT] = s_q.last_fe;
        end
        REG_IRQ_STAT: rw[IRQ_W-1:0] = s_q.irq_stat;
        REG_IRQ_MASK: rw[IRQ_W-1:0] = s_q.irq_mask;
        default: rw = '0;
      endcase
      s_d.rvalid = 1'b1;
      s_d.rdata = rw;
      s_d.rresp = is_reg(AXI_ARADDR_IN) ? RESP_OKAY : RESP_SLVERR;
    end
    s_d.arready = !s_d.rvalid;

    spb = s_q.dbl ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
    sfirst = s_q.dbl ? FIRST_DOUBLE : FIRST_NORMAL;
    smid = sfirst + 5'h01;
    slast = sfirst + 5'h02;
    // Out-of-range lengths are clamped rather than refused
    if (s_q.fbits < FRAME_MIN) begin
      fb = FRAME_MIN;
    end else if (s_q.fbits > FRAME_MAX) begin
      fb = FRAME_MAX;
    end else begin
      fb = s_q.fbits;
    end

    if (!s_q.en) begin
      s_d.fsm = UARX_IDLE;
      s_d.baud_cnt = '0;
      s_d.samp = '0;
      s_d.armed = 1'b0;
    end else if (s_q.baud_cnt != '0) begin
      s_d.baud_cnt = s_q.baud_cnt - DIV_W'(1);
    end else begin
      // One sample tick every baud divisor plus one clocks
      s_d.baud_cnt = s_q.baud;
      nsamp = (s_q.samp == spb) ? 5'h01 : s_q.samp + 5'h01;
      bidx = (s_q.samp == spb) ? s_q.bitn + 4'h1 : s_q.bitn;
      vote = maj3(s_q.votes[1], s_q.votes[0], s_q.sync2);
      if (nsamp == sfirst) begin
        s_d.votes[1] = s_q.sync2;
      end
      if (nsamp == smid) begin
        s_d.votes[0] = s_q.sync2;
      end
      unique case (s_q.fsm)
        UARX_IDLE: begin
          if (s_q.sync2) begin
            s_d.armed = 1'b1;
          end else if (s_q.armed) begin
            s_d.fsm = UARX_START;
            s_d.samp = 5'h01;
            s_d.frame = '0;
          end
        end
        UARX_START: begin
          s_d.samp = nsamp;
          if (nsamp == slast && vote) begin
            s_d.fsm = UARX_IDLE;
            s_d.armed = s_q.sync2;
            irq_set[IRQ_NOISE_BIT] = 1'b1;
          end else if (s_q.samp == spb) begin
            // Bit grid now runs from this start bit
            s_d.fsm = UARX_DATA;
            s_d.bitn = '0;
          end
        end
        UARX_DATA: begin
          s_d.samp = nsamp;
          s_d.bitn = bidx;
          if (nsamp == slast) begin
            if (bidx < fb) begin
              s_d.frame[bidx] = vote;
            end else begin
              // Later stop bits are never looked at
              s_d.fsm = UARX_IDLE;
              s_d.armed = vote;
              s_d.rx_valid = 1'b1;
              s_d.rx_data = s_q.frame;
              s_d.rx_fe = !vote;
              s_d.last_data = s_q.frame;
              s_d.last_fe = !vote;
              irq_set[IRQ_FRAME_BIT] = 1'b1;
              irq_set[IRQ_FERR_BIT] = !vote;
            end
          end
        end
        default: begin
          s_d.fsm = UARX_IDLE;
        end
      endcase
    end

    // A new event outweighs a clear in the same cycle
    s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      s_q <= S_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign AXI_AWREADY_OUT = s_q.awready;
  assign AXI_WREADY_OUT = s_q.wready;
  assign AXI_BVALID_OUT = s_q.bvalid;
  assign AXI_BRESP_OUT = s_q.bresp;
  assign AXI_ARREADY_OUT = s_q.arready;
  assign AXI_RVALID_OUT = s_q.rvalid;
  assign AXI_RDATA_OUT = s_q.rdata;
  assign AXI_RRESP_OUT = s_q.rresp;
  assign RX_VALID_OUT = s_q.rx_valid;
  assign RX_DATA_OUT = s_q.rx_data;
  assign RX_FE_OUT = s_q.rx_fe;
  assign IRQ_OUT = s_q.irq;

endmodule

// ---- include/uarx_pkg.sv ----
/*
  Constants, register map and state codes for the asynchronous receive
  recovery block. Assumes a single system clock and an AXI4-Lite master.
*/
package uarx_pkg;
  localparam int AXI_AW = 5;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_BAUD = 5'h04;
  localparam logic [4:0] REG_STATUS = 5'h08;
  localparam logic [4:0] REG_DATA = 5'h0c;
  localparam logic [4:0] REG_IRQ_STAT = 5'h10;
  localparam logic [4:0] REG_IRQ_MASK = 5'h14;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DBL_BIT = 1;
  localparam int CTRL_FBITS_LSB = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LINE_BIT = 1;
  localparam int STAT_FE_BIT = 2;
  localparam int DATA_FE_BIT = 16;
  localparam int IRQ_FRAME_BIT = 0;
  localparam int IRQ_FERR_BIT = 1;
  localparam int IRQ_NOISE_BIT = 2;
  localparam int IRQ_W = 3;
  localparam int FRAME_W = 10;
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic CTRL_DBL_RST = 1'b0;
  localparam logic [3:0] FBITS_RST = 4'h8;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
  localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
  localparam logic [4:0] FIRST_NORMAL = 5'h08;
  localparam logic [4:0] FIRST_DOUBLE = 5'h04;
  localparam logic [3:0] FRAME_MIN = 4'h5;
  localparam logic [3:0] FRAME_MAX = 4'ha;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    UARX_IDLE = 3'b001,
    UARX_START = 3'b010,
    UARX_DATA = 3'b100
  } uarx_fsm_t;
endpackage

// ---- verification/uart_async_rx_recovery_tb.sv ----
/* Self-checking bench for the receive front end.
   Assumes the checker is bound in and the line model drives the serial input. */
module uart_async_rx_recovery_tb import uarx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, rxd, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awr, wrr, bv, arr, rv, rxv, rxfe, irq;
  logic [4:0] awa = 5'h00, ara = 5'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0] br, rr;
  logic [9:0] rxdat;
  logic [9:0] qd[$];
  logic qf[$];
  int n_errors = 0, n_compared = 0;
  int dl[8] = '{0, 0, 0, 0, 1, 1, 0, 0};
  int dd[8] = '{8, 8, 8, 8, 10, 10, 5, 5};
  logic [9:0] dv[8] = '{10'h0a5, 10'h03c, 10'h05a, 10'h081, 10'h2b3, 10'h155, 10'h015, 10'h00a};
  logic ds[8] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  int sl[8] = '{16, 12, 16, 16, 6, 16, 32, 16};
  int dg[8] = '{-1, 2, -1, -1, -1, -1, 3, -1};
  always #50 clk = ~clk;
  uarx_top dut_u (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .RXD_IN(rxd),
    .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr), .AXI_AWADDR_IN(awa), .AXI_WVALID_IN(wv),
    .AXI_WREADY_OUT(wrr), .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(4'hf), .AXI_BVALID_OUT(bv),
    .AXI_BREADY_IN(bry), .AXI_BRESP_OUT(br), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr),
    .AXI_ARADDR_IN(ara), .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rry), .AXI_RDATA_OUT(rdat),
    .AXI_RRESP_OUT(rr), .RX_VALID_OUT(rxv), .RX_DATA_OUT(rxdat), .RX_FE_OUT(rxfe), .IRQ_OUT(irq));
  uarx_tx_model tx_u (.clk_in(clk), .line_out(rxd));
  always @(posedge clk) if (rxv === 1'b1) begin
    qd.push_back(rxdat);
    qf.push_back(rxfe);
  end
  task automatic wrap_up;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] e);
    int t;
    t = 0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (awr) awv <= 1'b0;
      if (wrr) wv <= 1'b0;
    end while (bv !== 1'b1 && t < 40);
    bry <= 1'b0;
    // Only a missing answer is a timeout, not one seen on the last try
    if (bv !== 1'b1) begin
      n_errors++;
      wrap_up;
    end
    chk("bresp", 32'(e), 32'(br));
    @(posedge clk);
  endtask
  task automatic rc(input string n, input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
    int t;
    t = 0;
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1 && t < 40);
    rry <= 1'b0;
    if (rv !== 1'b1) begin
      n_errors++;
      wrap_up;
    end
    chk(n, e, rdat);
    chk("rresp", 32'(er), 32'(rr));
    @(posedge clk);
  endtask
  initial begin
    int i;
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rc("ctrl", REG_CTRL, 32'h80, RESP_OKAY);
    rc("hole", 5'h18, 0, RESP_SLVERR);
    wr(5'h18, 32'hff, RESP_SLVERR);
    wr(REG_IRQ_MASK, 32'h7, RESP_OKAY);
    for (i = 0; i < 8; i++) begin
      if (i == 0 || dd[i] != dd[i-1] || dl[i] != dl[i-1]) wr(REG_CTRL, 32'(dd[i] * 16 + dl[i] * 2 + 1), RESP_OKAY);
      tx_u.send(dv[i], dd[i], dl[i] ? 8 : 16, ds[i], sl[i], dg[i]);
    end
    repeat (4) @(posedge clk);
    chk("frames", 8, qd.size());
    for (i = 0; i < 8; i++) begin
      chk("data", 32'(dv[i] & 10'((1 << dd[i]) - 1)), 32'(qd[i]));
      chk("fe", 32'(!ds[i]), 32'(qf[i]));
    end
    chk("irq", 1, 32'(irq));
    rc("istat", REG_IRQ_STAT, 32'h3, RESP_OKAY);
    wr(REG_IRQ_STAT, 32'h3, RESP_OKAY);
    rc("istat", REG_IRQ_STAT, 0, RESP_OKAY);
    wr(REG_IRQ_MASK, 0, RESP_OKAY);
    tx_u.pulse(4);
    repeat (40) @(posedge clk);
    rc("istat", REG_IRQ_STAT, 32'h4, RESP_OKAY);
    chk("irq", 0, 32'(irq));
    wr(REG_IRQ_MASK, 32'h4, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("irq", 1, 32'(irq));
    fork
      tx_u.send(10'h0ff, 5, 16, 1'b1, 16, -1);
      begin
        repeat (50) @(posedge clk);
        wr(REG_CTRL, 32'h50, RESP_OKAY);
      end
    join
    repeat (4) @(posedge clk);
    chk("frames", 8, qd.size());
    rc("status", REG_STATUS, 32'h6, RESP_OKAY);
    rc("data", REG_DATA, 32'h1000a, RESP_OKAY);
    // Divisor one: a sample tick every second clock, two clocks per sample
    wr(REG_BAUD, 32'h1, RESP_OKAY);
    rc("baud", REG_BAUD, 32'h1, RESP_OKAY);
    wr(REG_CTRL, 32'h81, RESP_OKAY);
    tx_u.send(10'h0c3, 8, 32, 1'b1, 32, 3);
    repeat (4) @(posedge clk);
    chk("frames", 9, qd.size());
    chk("data", 32'h0c3, 32'(qd[8]));
    chk("fe", 0, 32'(qf[8]));
    wrap_up;
  end
endmodule

// ---- verification/uarx_monitor.sv ----
/* Port checker for the receive front end.
   Assumes it is bound to uarx_top and sees only its ports. */
module uarx_monitor import uarx_pkg::*; (
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic AXI_AWREADY_OUT,
  input wire logic AXI_WREADY_OUT,
  input wire logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  input wire logic [1:0] AXI_BRESP_OUT,
  input wire logic AXI_ARVALID_IN,
  input wire logic AXI_ARREADY_OUT,
  input wire logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN,
  input wire logic [31:0] AXI_RDATA_OUT,
  input wire logic RX_VALID_OUT,
  input wire logic [FRAME_W-1:0] RX_DATA_OUT,
  input wire logic RX_FE_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // Shortest frame spans far more than eight clocks
  a_frame_pulse: assert property (RX_VALID_OUT |=> !RX_VALID_OUT [*8])
    else $error("frame pulse repeated too soon");
  a_data_hold: assert property (!RX_VALID_OUT |-> $stable(RX_DATA_OUT))
    else $error("frame data changed without pulse");
  a_fe_hold: assert property (!RX_VALID_OUT |-> $stable(RX_FE_OUT))
    else $error("framing flag changed without pulse");
  a_b_stands: assert property (AXI_BVALID_OUT && !AXI_BREADY_IN |=> AXI_BVALID_OUT && $stable(AXI_BRESP_OUT))
    else $error("write response dropped early");
  a_r_stands: assert property (AXI_RVALID_OUT && !AXI_RREADY_IN |=> AXI_RVALID_OUT && $stable(AXI_RDATA_OUT))
    else $error("read data dropped early");
  a_ar_refuse: assert property (AXI_RVALID_OUT |-> !AXI_ARREADY_OUT)
    else $error("read address open during response");
  a_aw_refuse: assert property (AXI_BVALID_OUT |-> !AXI_AWREADY_OUT && !AXI_WREADY_OUT)
    else $error("write open during response");
  a_read_lat: assert property (AXI_ARVALID_IN && AXI_ARREADY_OUT |=> AXI_RVALID_OUT)
    else $error("read answer late");
endmodule
bind uarx_top uarx_monitor mon_u (.CORE_CLK_IN, .SYS_RST_IN, .AXI_AWREADY_OUT, .AXI_WREADY_OUT,
  .AXI_BVALID_OUT, .AXI_BREADY_IN, .AXI_BRESP_OUT, .AXI_ARVALID_IN, .AXI_ARREADY_OUT,
  .AXI_RVALID_OUT, .AXI_RREADY_IN, .AXI_RDATA_OUT, .RX_VALID_OUT, .RX_DATA_OUT, .RX_FE_OUT);

// ---- verification/uarx_tx_model.sv ----
/* Line model of the remote transmitter, idle high.
   Assumes one caller at a time, clocked by the system clock. */
module uarx_tx_model (
  input wire logic clk_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial line_out = 1'b1;
  // Bit period equals the receiver's, so our share of rate error is nil
  task automatic send(input logic [9:0] v, input int d, s, input logic stp, input int sl, g);
    int i, c, n;
    logic b;
    for (i = 0; i < d + 2; i++) begin
      b = (i == 0) ? 1'b0 : (i > d) ? stp : v[i-1];
      n = (i > d) ? sl : s;
      for (c = 0; c < n; c++) begin
        @(posedge clk_in);
        // One upset clock can spoil only one centre sample
        line_out <= (i == g + 1 && c == s / 2) ? ~b : b;
      end
    end
    @(posedge clk_in);
    line_out <= 1'b1;
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_in);
      line_out <= 1'b0;
    end
    @(posedge clk_in);
    line_out <= 1'b1;
  endtask
endmodule
